// >>> rtl/cdl_defs.svh
// Offsets, field positions, reset values and timing counts of the cooler control
`ifndef CDL_DEFS_SVH
`define CDL_DEFS_SVH
// ****************************************
// Clock and time base
// ****************************************
`define CDL_CLK_MHZ 100
`define CDL_TICK_US 1000
`define CDL_TICK_CYCLES (`CDL_TICK_US * `CDL_CLK_MHZ)
// Times below are counted in 1 ms ticks
`define CDL_SEQ_STEP_MS 1000
`define CDL_HOLD_MS 500
`define CDL_IDLE_MS 5000
`define CDL_DOOR_MSG_MS 30000
`define CDL_BEEP_REPEAT_MS 30000
`define CDL_BEEP_MS 100
`define CDL_FAST_MS 150
`define CDL_MIN_MS 60000
`define CDL_DELAY_MAX 20
`define CDL_SP_MAX 39
`define CDL_SP_MIN -40
// ****************************************
// Register offsets
// ****************************************
`define CDL_CFG0_OFS 8'h00
`define CDL_CFG1_OFS 8'h04
`define CDL_STATUS_OFS 8'h08
`define CDL_SETPOINT_OFS 8'h0C
`define CDL_IRQ_STAT_OFS 8'h10
`define CDL_IRQ_EN_OFS 8'h14
`define CDL_IRQ_CLR_OFS 8'h18
// ****************************************
// Field positions and reset values
// ****************************************
`define CDL_F_START 1:0
`define CDL_F_AUX 3:2
`define CDL_F_LIGHT 5:4
`define CDL_F_LOC 6
`define CDL_F_BUZZ 7
`define CDL_F_DELAY 12:8
`define CDL_F_STILL 19:16
`define CDL_F_MAXDFT 7:0
`define CDL_F_ENDT 15:8
`define CDL_CFG0_RST 32'h000301F8
`define CDL_CFG1_RST 32'h0000051E
`define CDL_SETPOINT_RST 8'h02
`define CDL_IRQ_BITS 5
`endif

// >>> rtl/cdl_pkg.sv
// Types shared by the cooler control block
package cdl_pkg;
  typedef enum logic [2:0] {
    CDL_ST_DOTS1 = 3'b000,
    CDL_ST_REL = 3'b001,
    CDL_ST_DOTS2 = 3'b010,
    CDL_ST_STANDBY = 3'b011,
    CDL_ST_RUN = 3'b100
  } cdl_state_type;
  typedef enum logic [2:0] {
    CDL_DISP_DOTS = 3'b000,
    CDL_DISP_RELEASE = 3'b001,
    CDL_DISP_DASHES = 3'b010,
    CDL_DISP_TEMP = 3'b011,
    CDL_DISP_SETPOINT = 3'b100,
    CDL_DISP_DOOR = 3'b101,
    CDL_DISP_DEFROST = 3'b110
  } cdl_disp_type;
endpackage

// >>> rtl/cdl_ctrl.sv
// Cooler door, light, defrost and keypad control with APB registers
// How it works
// - At start, defrost never, only after outage during defrost, or always
// - Auxiliary input is none, door closed-when-open, door open-when-open, window sensor
// - Light follows door, keyboard, or both, per lighting selection
// - Door open 30 s shows the door message
// - With buzzer, short beep at message, repeated every 30 s
// - After alarm delay with door open: flash message unless defrosting, buzzer on, compressor off
// - Zero alarm delay raises alarm at once on opening
// - Door sensor read from actuator module or control module input
// - Power-up: dots 1 s, release, dots 1 s, then dashes
// - On/off key from standby starts running, showing chamber temperature
// - Up or down held 0.5 s enters flashing setpoint entry
// - Each press steps setpoint by one; holding steps faster
// - Five seconds with neither up nor down held leaves entry and stores setpoint
// - Drying key toggles drying mode; green LED shows it
// - Defrost key lights its LED, shows defrost message, starts defrost
// - Defrost ends on time limit or evaporator end temperature
// - Defrost limit 0 to 127 minutes; -1 means no time limit
`include "cdl_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module cdl_ctrl
  import cdl_pkg::*;
#(
  parameter int TICK_CYCLES = `CDL_TICK_CYCLES,
  parameter logic signed [7:0] SW_RELEASE = 8'h03
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic key_onoff,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_dry,
  input wire logic key_defrost,
  input wire logic key_light,
  input wire logic door_act_in,
  input wire logic door_ctl_in,
  input wire logic outage_in_defrost,
  input wire logic signed [7:0] chamber_temp,
  input wire logic signed [7:0] evap_temp,
  output cdl_disp_type disp_code,
  output logic signed [7:0] disp_value,
  output logic disp_flash,
  output logic buzzer,
  output logic light_out,
  output logic comp_permit,
  output logic defrost_heat,
  output logic led_dry,
  output logic led_defrost,
  output logic irq
);
  // ****************************************
  // Parameter check
  // ****************************************
  // Tick counter is 17 bits wide; one clock per tick is allowed for fast runs
  if (TICK_CYCLES < 1 || TICK_CYCLES > 131072) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  // ****************************************
  // Pin synchronisers and key edges
  // ****************************************
  logic [8:0] pin_raw;
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic [8:0] sync3;
  logic [8:0] pin_flt;
  logic [8:0] pin_flt_d;
  wire [8:0] pin_press = pin_flt & ~pin_flt_d;
  assign pin_raw = {outage_in_defrost, door_ctl_in, door_act_in, key_light,
                    key_defrost, key_dry, key_down, key_up, key_onoff};
  wire k_onoff = pin_press[0];
  wire up_held = pin_flt[1];
  wire dn_held = pin_flt[2];
  wire k_up = pin_press[1];
  wire k_dn = pin_press[2];
  wire k_dry = pin_press[3];
  wire k_dft = pin_press[4];
  wire k_light = pin_press[5];

  // Three stages; a bit moves only when stages two and three agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pin_flt <= '0;
      pin_flt_d <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_flt <= (sync2 & sync3) | (pin_flt & (sync2 ^ sync3));
      pin_flt_d <= pin_flt;
    end
  end

  // ****************************************
  // Millisecond tick
  // ****************************************
  logic [16:0] tick_cnt;
  wire ms_tick = (tick_cnt == 17'(TICK_CYCLES - 1));

  // Free running, so every timer shares one phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) tick_cnt <= '0;
    else tick_cnt <= ms_tick ? 17'h0_0000 : tick_cnt + 17'h0_0001;
  end

  // ****************************************
  // APB registers
  // ****************************************
  logic [31:0] cfg0;
  logic [31:0] cfg1;
  logic signed [7:0] setpoint;
  logic [`CDL_IRQ_BITS-1:0] irq_stat;
  logic [`CDL_IRQ_BITS-1:0] irq_en;
  logic [`CDL_IRQ_BITS-1:0] irq_evt;
  logic [31:0] status_word;
  logic [31:0] rdata_mux;
  logic sp_store;
  logic signed [7:0] edit_sp;
  wire wr_en = psel & penable & pwrite;
  wire hit_cfg0 = (paddr == `CDL_CFG0_OFS);
  wire hit_cfg1 = (paddr == `CDL_CFG1_OFS);
  wire hit_stat = (paddr == `CDL_STATUS_OFS);
  wire hit_sp = (paddr == `CDL_SETPOINT_OFS);
  wire hit_is = (paddr == `CDL_IRQ_STAT_OFS);
  wire hit_ie = (paddr == `CDL_IRQ_EN_OFS);
  wire hit_ic = (paddr == `CDL_IRQ_CLR_OFS);
  wire addr_ok = hit_cfg0 | hit_cfg1 | hit_stat | hit_sp | hit_is | hit_ie | hit_ic;
  wire [4:0] delay_wr = pwdata[`CDL_F_DELAY];
  // Oversized delay is clipped so the alarm limit stays in range
  wire [4:0] delay_lim = (delay_wr > 5'd`CDL_DELAY_MAX) ? 5'd`CDL_DELAY_MAX : delay_wr;

  // Config fields
  wire [1:0] startup_defrost_sel = cfg0[`CDL_F_START];
  wire [1:0] aux_sensor_type = cfg0[`CDL_F_AUX];
  wire [1:0] light_source_sel = cfg0[`CDL_F_LIGHT];
  wire door_sensor_location = cfg0[`CDL_F_LOC];
  wire buzzer_fitted = cfg0[`CDL_F_BUZZ];
  wire [4:0] door_alarm_delay = cfg0[`CDL_F_DELAY];
  wire [3:0] min_standstill = cfg0[`CDL_F_STILL];
  wire signed [7:0] max_defrost_time = cfg1[`CDL_F_MAXDFT];
  wire signed [7:0] defrost_end_temp = cfg1[`CDL_F_ENDT];

  // Read mux; unmapped reads return zero with pslverr
  assign rdata_mux = hit_cfg0 ? cfg0 : hit_cfg1 ? cfg1 : hit_stat ? status_word :
                     hit_sp ? {24'h00_0000, setpoint} :
                     hit_is ? {27'h000_0000, irq_stat} :
                     hit_ie ? {27'h000_0000, irq_en} : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign irq = |(irq_stat & irq_en);

  // Config and enable writes; read data caught in the setup cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg0 <= `CDL_CFG0_RST;
      cfg1 <= `CDL_CFG1_RST;
      irq_en <= '0;
      prdata <= '0;
    end else begin
      if (wr_en && hit_cfg0) cfg0 <= {12'h000, pwdata[19:16], 3'h0, delay_lim, pwdata[7:0]};
      if (wr_en && hit_cfg1) cfg1 <= {16'h0000, pwdata[15:0]};
      if (wr_en && hit_ie) irq_en <= pwdata[`CDL_IRQ_BITS-1:0];
      if (psel && !penable) prdata <= rdata_mux;
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) irq_stat <= '0;
    else irq_stat <= (irq_stat & ~((wr_en && hit_ic) ? pwdata[`CDL_IRQ_BITS-1:0] : '0))
                     | irq_evt;
  end

  // ****************************************
  // Power-up sequence and run state
  // ****************************************
  cdl_state_type state;
  cdl_state_type next_state;
  logic [9:0] seq_ms;
  logic boot_dft;
  wire seq_done = ms_tick && (seq_ms == 10'(`CDL_SEQ_STEP_MS - 1));
  wire running = (state == CDL_ST_RUN);

  always_comb begin
    next_state = state;
    case (state)
      CDL_ST_DOTS1: if (seq_done) next_state = CDL_ST_REL;
      CDL_ST_REL: if (seq_done) next_state = CDL_ST_DOTS2;
      CDL_ST_DOTS2: if (seq_done) next_state = CDL_ST_STANDBY;
      // on/off key toggles run and standby
      CDL_ST_STANDBY: if (k_onoff) next_state = CDL_ST_RUN;
      CDL_ST_RUN: if (k_onoff) next_state = CDL_ST_STANDBY;
      default: next_state = CDL_ST_DOTS1;
    endcase
  end

  // Outage flag is sampled as the sequence ends, long after it has settled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= CDL_ST_DOTS1;
      seq_ms <= '0;
      boot_dft <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state) seq_ms <= '0;
      else if (ms_tick) seq_ms <= seq_ms + 10'h001;
      // start-up defrost choice, consumed at the first start
      if (state == CDL_ST_DOTS2 && seq_done)
        boot_dft <= (startup_defrost_sel == 2'h2) ||
                    (startup_defrost_sel == 2'h1 && pin_flt[8]);
      else if (running) boot_dft <= 1'b0;
    end
  end

  // ****************************************
  // Door sensing and alarm timing
  // ****************************************
  logic [20:0] door_ms;
  logic [14:0] beep_ms;
  logic [19:0] still_ms;
  logic alarm_d;
  logic door_msg_d;
  wire door_pin = door_sensor_location ? pin_flt[6] : pin_flt[7];
  // polarity by sensor type; types 0 and 3 have no door
  wire door_open = (aux_sensor_type == 2'h1) ? door_pin :
                   (aux_sensor_type == 2'h2) ? ~door_pin : 1'b0;
  wire [20:0] alarm_lim = 21'(door_alarm_delay) * 21'(`CDL_MIN_MS);
  wire door_live = door_open & running;
  wire door_open_msg = door_live && (door_ms >= 21'(`CDL_DOOR_MSG_MS));
  // delay expiry, or zero delay alarms at once
  wire door_alarm = door_live && (door_alarm_delay == 5'h00 || door_ms >= alarm_lim);
  // short beep each time the repeat counter restarts
  wire beep = door_open_msg && (beep_ms < 15'(`CDL_BEEP_MS));

  // Door timers; standstill loaded as the alarm clears
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      door_ms <= '0;
      beep_ms <= '0;
      still_ms <= '0;
      alarm_d <= 1'b0;
      door_msg_d <= 1'b0;
    end else begin
      alarm_d <= door_alarm;
      door_msg_d <= door_open_msg;
      if (!door_live) door_ms <= '0;
      else if (ms_tick && door_ms != '1) door_ms <= door_ms + 21'h00_0001;
      if (!door_open_msg) beep_ms <= '0;
      else if (ms_tick)
        beep_ms <= (beep_ms == 15'(`CDL_BEEP_REPEAT_MS - 1)) ? 15'h0000 : beep_ms + 15'h0001;
      // compressor held off for the minimum standstill after a door alarm clears
      if (alarm_d && !door_alarm) still_ms <= 20'(min_standstill) * 20'(`CDL_MIN_MS);
      else if (ms_tick && still_ms != '0) still_ms <= still_ms - 20'h0_0001;
    end
  end

  // ****************************************
  // Defrost, drying and light
  // ****************************************
  logic defrost;
  logic [22:0] dft_ms;
  logic drying;
  logic light_key_on;
  wire [22:0] dft_lim = 23'(max_defrost_time[6:0]) * 23'(`CDL_MIN_MS);
  // negative limit means no time limit
  wire dft_timeout = !max_defrost_time[7] && (dft_ms >= dft_lim);
  // first of time or evaporator temperature ends it
  wire dft_end = defrost && (dft_timeout || evap_temp >= defrost_end_temp || !running);
  // key or start-up choice starts a cycle
  wire dft_start = !defrost && running && (k_dft || boot_dft);

  // Defrost cycle and the two toggles
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      defrost <= 1'b0;
      dft_ms <= '0;
      drying <= 1'b0;
      light_key_on <= 1'b0;
    end else begin
      if (dft_start) defrost <= 1'b1;
      else if (dft_end) defrost <= 1'b0;
      if (!defrost) dft_ms <= '0;
      else if (ms_tick && dft_ms != '1) dft_ms <= dft_ms + 23'h00_0001;
      if (running && k_dry) drying <= ~drying;
      if (k_light) light_key_on <= ~light_key_on;
    end
  end

  wire light_next = (light_source_sel == 2'h1) ? door_open :
                    (light_source_sel == 2'h2) ? light_key_on :
                    (light_source_sel == 2'h3) ? (door_open | light_key_on) : 1'b0;

  // ****************************************
  // Setpoint entry
  // ****************************************
  logic ent_active;
  logic [9:0] hold_ms;
  logic [7:0] rpt_ms;
  logic [12:0] idle_ms;
  wire any_held = up_held | dn_held;
  wire hold_done = hold_ms == 10'(`CDL_HOLD_MS);
  wire rpt_step = ms_tick && any_held && hold_done && (rpt_ms == 8'(`CDL_FAST_MS - 1));
  wire step_up = ent_active && (k_up || (rpt_step && up_held));
  wire step_dn = ent_active && (k_dn || (rpt_step && dn_held && !up_held));
  wire ent_enter = running && !ent_active && ms_tick && any_held && hold_done;
  assign sp_store = ent_active && ms_tick && !any_held &&
                    (idle_ms == 13'(`CDL_IDLE_MS - 1));

  // Hold, repeat and idle counters in ms ticks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_ms <= '0;
      rpt_ms <= '0;
      idle_ms <= '0;
    end else begin
      if (!any_held || ent_enter) hold_ms <= '0;
      else if (ms_tick && !hold_done) hold_ms <= hold_ms + 10'h001;
      if (!hold_done || rpt_step) rpt_ms <= '0;
      else if (ms_tick) rpt_ms <= rpt_ms + 8'h01;
      if (any_held || !ent_active) idle_ms <= '0;
      else if (ms_tick) idle_ms <= idle_ms + 13'h0001;
    end
  end

  // Entry value is clamped to the user range
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ent_active <= 1'b0;
      edit_sp <= `CDL_SETPOINT_RST;
      setpoint <= `CDL_SETPOINT_RST;
    end else begin
      // long hold enters entry with the stored value
      if (ent_enter) begin
        ent_active <= 1'b1;
        edit_sp <= setpoint;
      // single step per press, repeated while held
      end else if (step_up && edit_sp < 8'sd`CDL_SP_MAX) begin
        edit_sp <= edit_sp + 8'sd1;
      end else if (step_dn && edit_sp > -8'sd40) begin
        edit_sp <= edit_sp - 8'sd1;
      end
      if (sp_store || !running) ent_active <= 1'b0;
      if (sp_store) setpoint <= edit_sp;
      else if (wr_en && hit_sp) setpoint <= pwdata[7:0];
    end
  end

  // ****************************************
  // Status, events and outputs
  // ****************************************
  assign status_word = {21'h00_0000, ent_active, comp_permit, light_out, drying,
                        defrost, door_alarm, door_open_msg, door_open, state};
  assign irq_evt = {sp_store, dft_end, dft_start, door_alarm & ~alarm_d,
                    door_open_msg & ~door_msg_d};
  cdl_disp_type next_disp;
  logic signed [7:0] next_value;

  // Display priority: entry, defrost, door, temperature
  always_comb begin
    next_value = chamber_temp;
    case (state)
      CDL_ST_DOTS1, CDL_ST_DOTS2: next_disp = CDL_DISP_DOTS;
      CDL_ST_REL: begin
        next_disp = CDL_DISP_RELEASE;
        next_value = SW_RELEASE;
      end
      CDL_ST_STANDBY: next_disp = CDL_DISP_DASHES;
      CDL_ST_RUN: begin
        if (ent_active) begin
          next_disp = CDL_DISP_SETPOINT;
          next_value = edit_sp;
        end else if (defrost) next_disp = CDL_DISP_DEFROST;
        // alarm shows the door message even before the 30 s mark
        else if (door_open_msg || door_alarm) next_disp = CDL_DISP_DOOR;
        else next_disp = CDL_DISP_TEMP;
      end
      default: next_disp = CDL_DISP_DOTS;
    endcase
  end

  // Registered outputs, one cycle behind the state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      disp_code <= CDL_DISP_DOTS;
      disp_value <= '0;
      disp_flash <= 1'b0;
      buzzer <= 1'b0;
      light_out <= 1'b0;
      comp_permit <= 1'b0;
      defrost_heat <= 1'b0;
      led_dry <= 1'b0;
      led_defrost <= 1'b0;
    end else begin
      disp_code <= next_disp;
      disp_value <= next_value;
      disp_flash <= ent_active || (door_alarm && !defrost);
      buzzer <= buzzer_fitted && (beep || door_alarm);
      light_out <= light_next;
      // compressor off under alarm or standstill
      comp_permit <= running && !defrost && !door_alarm && still_ms == '0;
      defrost_heat <= defrost;
      led_dry <= drying;
      led_defrost <= defrost;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_leave_dots1;
    state == CDL_ST_DOTS1 ##1 state != CDL_ST_DOTS1;
  endsequence
  chk_power_seq_order: assert property (s_leave_dots1 |-> state == CDL_ST_REL)
    else $error("power-up sequence skipped release");
  chk_alarm_comp_off: assert property (door_alarm |=> !comp_permit)
    else $error("compressor allowed during door alarm");
  chk_zero_delay: assert property (door_live && door_alarm_delay == 5'h00 |=> buzzer == $past(buzzer_fitted))
    else $error("zero delay did not alarm at once");
  chk_msg_beep: assert property (buzzer_fitted && $rose(door_open_msg) |=> buzzer)
    else $error("no beep at door message");
  chk_dry_toggle: assert property (running && k_dry |=> drying != $past(drying))
    else $error("drying did not toggle");
  chk_defrost_key: assert property (dft_start |=> defrost ##1 led_defrost)
    else $error("defrost key did not start defrost");
  chk_defrost_end: assert property (defrost && evap_temp >= defrost_end_temp |=> !defrost)
    else $error("defrost did not end at temperature");
  chk_sp_store: assert property (sp_store |=> !ent_active && setpoint == $past(edit_sp))
    else $error("setpoint not stored on idle");
  chk_light_door: assert property (light_source_sel == 2'h1 |=> light_out == $past(door_open))
    else $error("light not following door");
endmodule
`default_nettype wire

// >>> test/cdl_far_model.sv
// Far-side model: keypad, door contact and outage flag of the appliance
`timescale 1ns/1ns
`default_nettype none
module cdl_far_model (
  input wire logic [5:0] key_hold,
  input wire logic door_open,
  input wire logic [1:0] aux_type,
  input wire logic location,
  input wire logic outage_flag,
  output logic [5:0] keys,
  output logic door_act_in,
  output logic door_ctl_in,
  output logic outage_in_defrost
);
  logic contact;
  assign contact = (aux_type == 2'h2) ? ~door_open : door_open;
  // only the selected location carries it; the other pin reads inverted
  assign door_act_in = location ? contact : ~contact;
  assign door_ctl_in = location ? ~contact : contact;
  // Keys pass straight through, pressed is high
  assign keys = key_hold;
  // Outage flag held by the bench across a power cycle
  assign outage_in_defrost = outage_flag;
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the cooler control block
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import cdl_pkg::*;
;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, door_open, location, serr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] key_hold, keys;
  logic [1:0] aux_type;
  logic door_act_in, door_ctl_in, outage, buzzer, light_out, comp_permit, defrost_heat;
  logic led_dry, led_defrost, irq, disp_flash, e, outage_flag;
  logic signed [7:0] chamber_temp, evap_temp, disp_value;
  cdl_disp_type disp_code;
  cdl_disp_type seq [4] = '{CDL_DISP_DOTS, CDL_DISP_RELEASE, CDL_DISP_DOTS, CDL_DISP_DASHES};
  logic [3:0] tab [4] = '{4'h5, 4'h2, 4'h4, 4'h7};
  int err_count, tests_run, t;
  // One-clock tick keeps every ms count in clock cycles
  cdl_ctrl #(.TICK_CYCLES(1)) dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .key_onoff(keys[0]), .key_up(keys[1]), .key_down(keys[2]),
    .key_dry(keys[3]), .key_defrost(keys[4]), .key_light(keys[5]), .door_act_in,
    .door_ctl_in, .outage_in_defrost(outage), .chamber_temp, .evap_temp, .disp_code,
    .disp_value, .disp_flash, .buzzer, .light_out, .comp_permit, .defrost_heat, .led_dry,
    .led_defrost, .irq);
  cdl_far_model far (.key_hold, .door_open, .aux_type, .location, .outage_flag, .keys, .door_act_in,
    .door_ctl_in, .outage_in_defrost(outage));
  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Waits on pready rather than trusting the one-cycle answer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic press(input int k, input int n);
    key_hold[k] <= 1'b1;
    repeat (n) @(posedge clock);
    key_hold[k] <= 1'b0;
    repeat (12) @(posedge clock);
  endtask
  // Setpoint after one step, clamped to the settable span
  function automatic int sp_step(input int sp, input int d);
    return (sp + d > 39) ? 39 : (sp + d < -40) ? -40 : sp + d;
  endfunction
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, door_open, location, rst_n, e, outage_flag} = '0;
    {paddr, pwdata, key_hold, aux_type} = '0;
    chamber_temp = -8'sd5;
    evap_temp = -8'sd10;
    t = $urandom(85);
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      repeat (i == 0 ? 500 : 1000) @(posedge clock);
      chk(disp_code, seq[i]);
      if (i == 1) chk(32'(disp_value), 32'h3);
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk(32'(serr), 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h000301F8);
    apb(1'b1, 8'h14, 32'h12);
    press(0, 4);
    chk(disp_code, CDL_DISP_TEMP);
    for (int i = 0; i < 4; i++) begin
      t = int'($urandom_range(70)) - 30;
      chamber_temp <= 8'(t);
      repeat (4) @(posedge clock);
      chk(32'(disp_value), 32'(t));
    end
    $display("power-up and start test done");
    // Door types and locations, zero alarm delay, light from door and keys
    for (int i = 0; i < 4; i++) begin
      aux_type <= tab[i][1:0];
      location <= tab[i][2];
      apb(1'b1, 8'h00, 32'hB0 | 32'(tab[i][1:0]) << 2 | 32'(tab[i][2]) << 6);
      e = (tab[i][1:0] == 2'h1) || (tab[i][1:0] == 2'h2);
      door_open <= 1'b1;
      repeat (10) @(posedge clock);
      chk({disp_flash, buzzer, comp_permit}, {e, e, ~e});
      chk(light_out, e);
      chk(disp_code, e ? CDL_DISP_DOOR : CDL_DISP_TEMP);
      if (i == 0) chk(irq, 1'b1);
      apb(1'b1, 8'h18, 32'h2);
      door_open <= 1'b0;
      repeat (10) @(posedge clock);
      chk({disp_flash, buzzer, irq, disp_code}, {3'b000, CDL_DISP_TEMP});
    end
    apb(1'b1, 8'h00, 32'hE4);
    press(5, 4);
    chk(light_out, 1'b1);
    press(3, 4);
    chk(led_dry, 1'b1);
    press(3, 4);
    chk(led_dry, 1'b0);
    $display("door, light and drying test done");
    apb(1'b1, 8'h00, 32'h1F4);
    door_open <= 1'b1;
    repeat (30010) @(posedge clock);
    chk({disp_code, disp_flash, buzzer}, {CDL_DISP_DOOR, 2'b01});
    repeat (200) @(posedge clock);
    chk(buzzer, 1'b0);
    repeat (29800) @(posedge clock);
    chk({disp_flash, buzzer, comp_permit}, 3'b110);
    door_open <= 1'b0;
    apb(1'b1, 8'h18, 32'h2);
    press(4, 4);
    chk({led_defrost, defrost_heat, disp_code}, {2'b11, CDL_DISP_DEFROST});
    evap_temp <= 8'sd10;
    repeat (5) @(posedge clock);
    chk({led_defrost, defrost_heat}, 2'b00);
    $display("door timing and defrost test done");
    press(1, 520);
    chk({disp_flash, disp_code}, {1'b1, CDL_DISP_SETPOINT});
    chk(32'(disp_value), 32'(sp_step(2, 0)));
    press(2, 4);
    chk(32'(disp_value), 32'(sp_step(2, -1)));
    repeat (5100) @(posedge clock);
    chk({disp_flash, irq}, 2'b01);
    apb(1'b0, 8'h0C, 32'h0);
    chk(32'(signed'(rd[7:0])), 32'(sp_step(2, -1)));
    $display("setpoint test done");
    // Start-up defrost per choice and outage flag, each after a fresh reset
    evap_temp <= -8'sd10;
    for (int i = 0; i < 3; i++) begin
      rst_n <= 1'b0;
      outage_flag <= (i == 1);
      e = (i != 0);
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      apb(1'b1, 8'h00, (i == 2) ? 32'h2 : 32'h1);
      repeat (3100) @(posedge clock);
      chk(disp_code, CDL_DISP_DASHES);
      press(0, 4);
      chk({led_defrost, defrost_heat}, {e, e});
    end
    $display("start-up defrost test done");
    finish_test();
  end
  // Full run is near 80000 cycles; the limit stops a hang at 100000
  initial begin
    #1000000;
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
